// ---- shared/rtcia_pkg.sv ----
// shared constants for the clock indirect access path
package rtcia_pkg;
  // interface register map (one byte each)
  localparam logic [1:0] RegKey = 2'h0;
  localparam logic [1:0] RegAddr = 2'h1;
  localparam logic [1:0] RegData = 2'h2;
  // unlock key codes
  localparam logic [7:0] KeyFirst = 8'hA5;
  localparam logic [7:0] KeySecond = 8'hF1;
  // key register status codes
  localparam logic [7:0] StLocked = 8'h00;
  localparam logic [7:0] StHalf = 8'h01;
  localparam logic [7:0] StOpen = 8'h02;
  localparam logic [7:0] StDead = 8'h03;
  // indirect address register fields
  localparam int BusyBit = 7;
  localparam int AutoBit = 6;
  localparam int AddrMsb = 3;
  // internal map
  localparam logic [3:0] IaSnap0 = 4'h0;
  localparam logic [3:0] IaSnap3 = 4'h3;
  localparam logic [3:0] IaCtl = 4'h4;
  localparam logic [3:0] IaOscCtl = 4'h5;
  localparam logic [3:0] IaOscCfg = 4'h6;
  localparam logic [3:0] IaAlarm0 = 4'h8;
  localparam logic [3:0] IaAlarm3 = 4'hB;
  // control bits
  localparam int CtlRunBit = 0;
  localparam int CtlAlarmEnBit = 1;
  localparam int CtlMissEnBit = 2;
  localparam int CtlCaptureBit = 3;
  localparam int CtlLoadBit = 4;
  localparam int CfgAutoStepBit = 4;
  localparam int CfgCapMsb = 3;
  // host command port map
  localparam logic [1:0] CmdKey = 2'h0;
  localparam logic [1:0] CmdAddr = 2'h1;
  localparam logic [1:0] CmdData = 2'h2;
  localparam logic [1:0] CmdStat = 2'h3;
  // clock cycles of slow tick with no edge before a missing clock event
  localparam logic [7:0] MissLimit = 8'hFF;
endpackage

// ---- shared/rtcia_if.sv ----
// link between host and device register port
`timescale 1ns/1ns
interface rtcia_if;
  logic [1:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  modport dev (input addr, input wdata, input wr, input rd, output rdata);
  modport host (output addr, output wdata, output wr, output rd,
    input rdata);
endinterface

// ---- logic/rtcia_device.sv ----
// device end: lock, indirect access and clock registers
//
// Contract
// R1: unlock needs key A5 then F1
// R2: no timeout between the two keys
// R3: bad key or locked access disables
// R4: unlimited accesses while unlocked
// R5: key write while unlocked relocks
// R6: key read shows status, harmless
// R7: internals reached only via address/data
// R8: address register selects indirect target
// R9: data write writes selected internal byte
// R10: busy bit starts an indirect read
// R11: read data holds until next operation
// R12: address and busy in one write
// R13: autoread: data read starts next read
// R14: host sets busy once, polls busy
// R15: address steps after snapshot/alarm byte
// R16: host rewrites address for single bytes
// R17: block transfers load address via select
// R18: snapshot bytes load and read timer
// R19: alarm bytes hold 32-bit alarm
// R20: alarm and missing clock events raised
// R21: sixteen capacitance levels plus auto step
// R22: disabled state ignores all until reset
// R23: busy high until read data valid
`timescale 1ns/1ns
module rtcia_device
  import rtcia_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  rtcia_if.dev bus,
  input wire logic slowTick,
  output logic alarmEvent,
  output logic missEvent,
  output logic [3:0] loadCap,
  output logic autoStep
);
  import rtcia_pkg::*;

  typedef enum logic [1:0]
  {
    LK_LOCKED = 2'b00,
    LK_HALF = 2'b01,
    LK_OPEN = 2'b10,
    LK_DEAD = 2'b11
  } rtcia_lock_e;

  rtcia_lock_e lock_ff;
  logic [7:0] addrReg_ff;
  logic [7:0] dataReg_ff;
  logic [7:0] rdata_ff;
  logic [31:0] timer_ff;
  logic [31:0] snap_ff;
  logic [31:0] alarm_ff;
  logic [7:0] ctl_ff;
  logic [7:0] oscCtl_ff;
  logic [7:0] oscCfg_ff;
  logic [7:0] missCnt_ff;
  logic alarmEvent_ff;
  logic missEvent_ff;
  logic busyPend_ff;

  logic keyWr, accWr, accRd, unlocked;
  logic [3:0] ia;
  logic [7:0] iaRead;
  logic blockByte;

  function automatic logic isBlock(input logic [3:0] a);
    isBlock = (a <= IaSnap3) || (a >= IaAlarm0 && a <= IaAlarm3);
  endfunction

  assign unlocked = (lock_ff == LK_OPEN);
  assign keyWr = bus.wr && bus.addr == RegKey;
  assign accWr = bus.wr && (bus.addr == RegAddr || bus.addr == RegData);
  assign accRd = bus.rd && (bus.addr == RegAddr || bus.addr == RegData);
  assign ia = addrReg_ff[AddrMsb:0]; // R8
  assign blockByte = isBlock(ia);

  // internal register read mux
  always_comb
  begin
    iaRead = 8'h00;
    case (ia)
      4'h0, 4'h1, 4'h2, 4'h3: iaRead = snap_ff[8*ia[1:0] +: 8];
      IaCtl: iaRead = ctl_ff;
      IaOscCtl: iaRead = oscCtl_ff;
      IaOscCfg: iaRead = oscCfg_ff;
      4'h8, 4'h9, 4'hA, 4'hB: iaRead = alarm_ff[8*ia[1:0] +: 8];
      default: iaRead = 8'h00;
    endcase
  end

  // lock state machine
  always_ff @(posedge clk)
  begin
    if (rst)
      lock_ff <= LK_LOCKED;
    else
      case (lock_ff)
        LK_LOCKED:
          if (keyWr) // R2
            lock_ff <= (bus.wdata == KeyFirst) ? LK_HALF : LK_DEAD; // R1 R3
          else if (accWr || accRd)
            lock_ff <= LK_DEAD; // R3
        LK_HALF:
          if (keyWr)
            lock_ff <= (bus.wdata == KeySecond) ? LK_OPEN : LK_DEAD; // R1 R3
          else if (accWr || accRd)
            lock_ff <= LK_DEAD; // R3
        LK_OPEN:
          if (keyWr)
            lock_ff <= LK_LOCKED; // R4 R5
        LK_DEAD: lock_ff <= LK_DEAD; // R22
        default: lock_ff <= LK_DEAD;
      endcase
  end

  // indirect address, data and busy
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      addrReg_ff <= 8'h00;
      dataReg_ff <= 8'h00;
      busyPend_ff <= 1'b0;
    end
    else if (unlocked) // R7
    begin
      busyPend_ff <= 1'b0;
      if (busyPend_ff)
      begin
        dataReg_ff <= iaRead; // R10 R11
        addrReg_ff[BusyBit] <= 1'b0; // R23
        if (blockByte)
          addrReg_ff[AddrMsb:0] <= ia + 4'h1; // R15
      end
      else if (bus.wr && bus.addr == RegAddr)
      begin
        addrReg_ff <= bus.wdata; // R8 R12
        busyPend_ff <= bus.wdata[BusyBit]; // R10 R12
      end
      else if (bus.wr && bus.addr == RegData)
      begin
        dataReg_ff <= bus.wdata; // R9
        if (blockByte)
          addrReg_ff[AddrMsb:0] <= ia + 4'h1; // R15
      end
      else if (bus.rd && bus.addr == RegData && addrReg_ff[AutoBit])
      begin
        addrReg_ff[BusyBit] <= 1'b1; // R13 R23
        busyPend_ff <= 1'b1; // R13
      end
    end
  end

  // internal registers and time base
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      timer_ff <= 32'h0000_0000;
      snap_ff <= 32'h0000_0000;
      alarm_ff <= 32'hFFFF_FFFF;
      ctl_ff <= 8'h00;
      oscCtl_ff <= 8'h00;
      oscCfg_ff <= 8'h00;
    end
    else
    begin
      if (ctl_ff[CtlRunBit] && slowTick)
        timer_ff <= timer_ff + 32'h1;
      if (unlocked && bus.wr && bus.addr == RegData && !busyPend_ff)
        case (ia)
          4'h0, 4'h1, 4'h2, 4'h3: snap_ff[8*ia[1:0] +: 8] <= bus.wdata; // R18
          IaCtl: ctl_ff <= bus.wdata;
          IaOscCtl: oscCtl_ff <= bus.wdata;
          IaOscCfg: oscCfg_ff <= bus.wdata; // R21
          4'h8, 4'h9, 4'hA, 4'hB: alarm_ff[8*ia[1:0] +: 8] <= bus.wdata; // R19
          default: ;
        endcase
      else if (ctl_ff[CtlCaptureBit])
      begin
        snap_ff <= timer_ff; // R18
        ctl_ff[CtlCaptureBit] <= 1'b0;
      end
      else if (ctl_ff[CtlLoadBit])
      begin
        timer_ff <= snap_ff; // R18
        ctl_ff[CtlLoadBit] <= 1'b0;
      end
    end
  end

  // alarm and missing clock events
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      missCnt_ff <= 8'h00;
      alarmEvent_ff <= 1'b0;
      missEvent_ff <= 1'b0;
    end
    else
    begin
      alarmEvent_ff <= ctl_ff[CtlAlarmEnBit] && timer_ff == alarm_ff; // R20
      if (slowTick || !ctl_ff[CtlMissEnBit])
        missCnt_ff <= 8'h00;
      else if (missCnt_ff != MissLimit)
        missCnt_ff <= missCnt_ff + 8'h01;
      missEvent_ff <= missCnt_ff == MissLimit; // R20
    end
  end

  // register read port, one cycle latency
  always_ff @(posedge clk)
  begin
    if (rst)
      rdata_ff <= 8'h00;
    else if (bus.rd)
      case (bus.addr)
        RegKey: rdata_ff <= (lock_ff == LK_OPEN) ? StOpen : // R6
          (lock_ff == LK_HALF) ? StHalf :
          (lock_ff == LK_DEAD) ? StDead : StLocked;
        RegAddr: rdata_ff <= unlocked ? addrReg_ff : 8'h00;
        RegData: rdata_ff <= unlocked ? dataReg_ff : 8'h00;
        default: rdata_ff <= 8'h00;
      endcase
  end

  assign bus.rdata = rdata_ff;
  assign alarmEvent = alarmEvent_ff;
  assign missEvent = missEvent_ff;
  assign loadCap = oscCfg_ff[CfgCapMsb:0]; // R21
  assign autoStep = oscCfg_ff[CfgAutoStepBit]; // R21
endmodule // rtcia_device

// ---- logic/rtcia_host.sv ----
// host end: forwards software commands onto the device port
`timescale 1ns/1ns
module rtcia_host
  import rtcia_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  rtcia_if.host bus,
  input wire logic [1:0] cmdAddr,
  input wire logic [7:0] cmdWdata,
  input wire logic cmdWr,
  input wire logic cmdRd,
  output logic [7:0] cmdRdata
);
  import rtcia_pkg::*;

  logic [1:0] addr_ff;
  logic [7:0] wdata_ff;
  logic wr_ff;
  logic rd_ff;
  logic rdPend_ff;
  logic [7:0] cmdRdata_ff;

  // drive device port one cycle after each key, address or data command (R14 R16 R17 by software)
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      addr_ff <= RegKey;
      wdata_ff <= 8'h00;
      wr_ff <= 1'b0;
      rd_ff <= 1'b0;
    end
    else
    begin
      wr_ff <= cmdWr && cmdAddr != CmdStat;
      rd_ff <= cmdRd && cmdAddr != CmdStat;
      if (cmdWr || cmdRd)
      begin
        addr_ff <= cmdAddr;
        wdata_ff <= cmdWdata;
      end
    end
  end

  // return device data; status slot reports whether a device read is still in flight
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rdPend_ff <= 1'b0;
      cmdRdata_ff <= 8'h00;
    end
    else
    begin
      rdPend_ff <= rd_ff;
      if (rdPend_ff)
        cmdRdata_ff <= bus.rdata;
      else if (cmdRd && cmdAddr == CmdStat)
        cmdRdata_ff <= {7'h00, rdPend_ff | rd_ff};
    end
  end

  assign bus.addr = addr_ff;
  assign bus.wdata = wdata_ff;
  assign bus.wr = wr_ff;
  assign bus.rd = rd_ff;
  assign cmdRdata = cmdRdata_ff;
endmodule // rtcia_host

// ---- verif/rtcia_assertions.sv ----
// link checker for the clock indirect access path
`timescale 1ns/1ns
module rtcia_assertions
  import rtcia_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata
);
  import rtcia_pkg::*;
  logic [1:0] st_ff;
  logic keyRd;
  logic lockRd;
  assign keyRd = rd && addr == RegKey;
  assign lockRd = rd && st_ff != 2'h2;
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  // lock state seen on the link
  always_ff @(posedge clk)
  begin
    if (rst)
      st_ff <= 2'h0;
    else if (wr && addr == RegKey && st_ff != 2'h3)
      st_ff <= st_ff == 2'h2 ? 2'h0 : wdata != (st_ff == 2'h0 ?
        KeyFirst : KeySecond) ? 2'h3 : st_ff + 2'h1;
    else if ((wr || rd) && addr != RegKey && st_ff != 2'h2)
      st_ff <= 2'h3;
  end
  AST_KEY_OPEN: assert property (
    keyRd && st_ff == 2'h2 |=> rdata == StOpen)
    else $error("status not open");
  AST_KEY_HALF: assert property (
    keyRd && st_ff == 2'h1 |=> rdata == StHalf)
    else $error("status not half");
  AST_KEY_LOCKED: assert property (
    keyRd && st_ff == 2'h0 |=> rdata == StLocked)
    else $error("status not locked");
  AST_KEY_DEAD: assert property (
    keyRd && st_ff == 2'h3 |=> rdata == StDead)
    else $error("status not disabled");
  AST_ADDR_LOCKED: assert property (
    lockRd && addr == RegAddr |=> rdata == 8'h00)
    else $error("address readable while locked");
  AST_DATA_LOCKED: assert property (
    lockRd && addr == RegData |=> rdata == 8'h00)
    else $error("data readable while locked");
  AST_RDATA_HOLD: assert property (
    !rd |=> $stable(rdata))
    else $error("read data moved without a read");
  AST_ONE_STROBE: assert property (
    !(wr && rd))
    else $error("read and write together");
endmodule // rtcia_assertions

// ---- verif/tb.sv ----
// bench for the clock indirect access path
`timescale 1ns/1ns
module tb;
  import rtcia_pkg::*;
  logic clk, rst, slowTick, cmdWr, cmdRd, alarmEvent, missEvent, autoStep;
  logic [1:0] cmdAddr;
  logic [7:0] cmdWdata, cmdRdata;
  logic [3:0] loadCap;
  int errors, compares;
  rtcia_if link();
  rtcia_host rtcia_host_i (.clk(clk), .rst(rst), .bus(link),
    .cmdAddr(cmdAddr), .cmdWdata(cmdWdata), .cmdWr(cmdWr), .cmdRd(cmdRd),
    .cmdRdata(cmdRdata));
  rtcia_device rtcia_device_i (.clk(clk), .rst(rst), .bus(link),
    .slowTick(slowTick), .alarmEvent(alarmEvent), .missEvent(missEvent),
    .loadCap(loadCap), .autoStep(autoStep));
  rtcia_assertions rtcia_assertions_i (.clk(clk), .rst(rst),
    .addr(link.addr), .wdata(link.wdata), .wr(link.wr), .rd(link.rd),
    .rdata(link.rdata));
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      errors++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(logic [1:0] a, logic [7:0] d);
    cmdAddr <= a;
    cmdWdata <= d;
    cmdWr <= 1'b1;
    @(posedge clk);
    cmdWr <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic rd(logic [1:0] a, logic [7:0] e, string n);
    cmdAddr <= a;
    cmdRd <= 1'b1;
    @(posedge clk);
    cmdRd <= 1'b0;
    repeat (4) @(posedge clk);
    chk(n, e, cmdRdata);
  endtask
  task automatic reset();
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask
  task automatic conclude();
    if (errors == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic t_unlock();
    rd(CmdKey, StLocked, "key0");
    wr(CmdKey, KeyFirst);
    rd(CmdKey, StHalf, "key1");
    repeat (40) @(posedge clk);
    wr(CmdKey, KeySecond);
    rd(CmdKey, StOpen, "key2");
  endtask
  task automatic t_block();
    wr(CmdAddr, 8'h08);
    for (int i = 1; i < 5; i++)
      wr(CmdData, 8'(i * 17));
    wr(CmdAddr, 8'hC8);
    for (int i = 1; i < 5; i++)
      rd(CmdData, 8'(i * 17), "alarm");
    rd(CmdAddr, 8'h4C, "addr");
  endtask
  task automatic t_single();
    wr(CmdAddr, 8'h02);
    wr(CmdData, 8'h5A);
    wr(CmdAddr, 8'h06);
    wr(CmdData, 8'h1A);
    chk("cap", 8'h0A, {4'h0, loadCap});
    chk("step", 8'h01, {7'h00, autoStep});
    wr(CmdAddr, 8'h82);
    rd(CmdAddr, 8'h03, "busy");
    rd(CmdData, 8'h5A, "snap");
    rd(CmdData, 8'h5A, "hold");
  endtask
  task automatic t_miss();
    wr(CmdAddr, 8'h04);
    wr(CmdData, 8'h04);
    repeat (300) @(posedge clk);
    chk("miss", 8'h01, {7'h00, missEvent});
    chk("alarm", 8'h00, {7'h00, alarmEvent});
  endtask
  task automatic t_timer();
    wr(CmdAddr, 8'h00);
    wr(CmdData, 8'h0E);
    wr(CmdData, 8'h22);
    wr(CmdData, 8'h33);
    wr(CmdData, 8'h44);
    wr(CmdAddr, 8'h04);
    wr(CmdData, 8'h13);
    repeat (3)
    begin
      slowTick <= 1'b1;
      @(posedge clk);
      slowTick <= 1'b0;
      @(posedge clk);
    end
    @(posedge clk);
    chk("alarmOn", 8'h01, {7'h00, alarmEvent});
    chk("missOff", 8'h00, {7'h00, missEvent});
    wr(CmdAddr, 8'h04);
    wr(CmdData, 8'h09);
    chk("alarmOff", 8'h00, {7'h00, alarmEvent});
    wr(CmdAddr, 8'h80);
    rd(CmdData, 8'h11, "capture");
    rd(CmdStat, 8'h00, "stat");
  endtask
  task automatic t_relock();
    wr(CmdKey, 8'h00);
    rd(CmdKey, StLocked, "relock");
    rd(CmdData, 8'h00, "locked");
    rd(CmdKey, StDead, "dead");
    rd(CmdAddr, 8'h00, "closed");
    wr(CmdKey, KeyFirst);
    wr(CmdKey, KeySecond);
    rd(CmdKey, StDead, "stuck");
  endtask
  task automatic t_badkeys();
    reset();
    wr(CmdKey, KeySecond);
    rd(CmdKey, StDead, "order");
    reset();
    wr(CmdKey, KeyFirst);
    wr(CmdKey, KeyFirst);
    rd(CmdKey, StDead, "code");
  endtask
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial
  begin
    rst = 1'b1;
    slowTick = 1'b0;
    {cmdWr, cmdRd, cmdAddr, cmdWdata} = '0;
    @(posedge clk);
    reset();
    t_unlock();
    t_block();
    t_single();
    t_miss();
    t_timer();
    t_relock();
    t_badkeys();
    conclude();
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    errors++;
    conclude();
  end
endmodule // tb
